//--- hw/dbg_host.sv
// Register host: byte commands and high-then-low fifo word reads
`timescale 1ns/1ps
`default_nettype none
module dbg_host (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    dbg_reg_if.host         regs,
    input  wire logic [3:0] cmd_addr_i,
    input  wire logic [7:0] cmd_wdata_i,
    input  wire logic       cmd_wr_i,
    input  wire logic       cmd_rd_i,
    input  wire logic       cmd_word_rd_i,
    input  wire logic       cmd_serial_i,
    output logic            busy_o,
    output logic [7:0]      byte_o,
    output logic            byte_valid_o,
    output logic [15:0]     word_o,
    output logic            word_valid_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HIGH = 4'b0010,
        ST_LOW  = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;

    state_t      state_ff;
    logic [3:0]  addr_ff;
    logic [7:0]  wdata_ff;
    logic        wr_ff;
    logic        rd_ff;
    logic        serial_ff;
    logic        rd_pend_ff;
    logic [7:0]  byte_ff;
    logic        byte_valid_ff;
    logic [15:0] word_ff;
    logic        word_valid_ff;

    // Word reads issue high then low, since low advances the fifo
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff  <= ST_IDLE;
            addr_ff   <= 4'h0;
            wdata_ff  <= dbg_pkg::BYTE_RESET;
            wr_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            serial_ff <= 1'b0;
        end else if (ce_i) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (cmd_word_rd_i) begin
                        addr_ff  <= dbg_pkg::FIFO_HIGH_IDX;
                        rd_ff    <= 1'b1;
                        state_ff <= ST_HIGH;
                    end else if (cmd_wr_i || cmd_rd_i) begin
                        addr_ff   <= cmd_addr_i;
                        wdata_ff  <= cmd_wdata_i;
                        wr_ff     <= cmd_wr_i;
                        rd_ff     <= cmd_rd_i && !cmd_wr_i;
                        serial_ff <= cmd_serial_i;
                    end
                end
                ST_HIGH: begin
                    addr_ff  <= dbg_pkg::FIFO_LOW_IDX;
                    rd_ff    <= 1'b1;
                    state_ff <= ST_LOW;
                end
                ST_LOW:  state_ff <= ST_DONE;
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Collect read answers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_pend_ff    <= 1'b0;
            byte_ff       <= dbg_pkg::BYTE_RESET;
            byte_valid_ff <= 1'b0;
            word_ff       <= dbg_pkg::WORD_RESET;
            word_valid_ff <= 1'b0;
        end else if (ce_i) begin
            rd_pend_ff    <= rd_ff && state_ff == ST_IDLE;
            byte_valid_ff <= rd_pend_ff;
            word_valid_ff <= state_ff == ST_DONE;
            if (rd_pend_ff) begin
                byte_ff <= regs.rdata;
            end
            if (state_ff == ST_LOW) begin
                word_ff[15:8] <= regs.rdata;
            end
            if (state_ff == ST_DONE) begin
                word_ff[7:0] <= regs.rdata;
            end
        end
    end

    assign regs.addr    = addr_ff;
    assign regs.wdata   = wdata_ff;
    assign regs.wr      = wr_ff;
    assign regs.rd      = rd_ff;
    assign regs.serial  = serial_ff;
    assign busy_o       = state_ff != ST_IDLE;
    assign byte_o       = byte_ff;
    assign byte_valid_o = byte_valid_ff;
    assign word_o       = word_ff;
    assign word_valid_o = word_valid_ff;
endmodule
`default_nettype wire

//--- hw/dbg_pkg.sv
// Shared constants for the debug trace module and its register host
package dbg_pkg;
    localparam int unsigned ADDR_W    = 4;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned CPU_ADDR_W = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned CNT_W     = 4;

    // Register indexes on the register port
    localparam logic [3:0] CMP_A_HIGH_IDX  = 4'h0;
    localparam logic [3:0] CMP_A_LOW_IDX   = 4'h1;
    localparam logic [3:0] CMP_B_HIGH_IDX  = 4'h2;
    localparam logic [3:0] CMP_B_LOW_IDX   = 4'h3;
    localparam logic [3:0] FIFO_HIGH_IDX   = 4'h4;
    localparam logic [3:0] FIFO_LOW_IDX    = 4'h5;
    localparam logic [3:0] CONTROL_IDX     = 4'h6;
    localparam logic [3:0] FORCE_RESET_IDX = 4'h7;

    // Control and force-reset register bit positions
    localparam int unsigned ENABLE_BIT  = 7;
    localparam int unsigned ARM_BIT     = 6;
    localparam int unsigned TAG_BIT     = 5;
    localparam int unsigned BREAK_ENABLE_BIT = 4;
    localparam int unsigned CMP_A_DIR_BIT    = 3;
    localparam int unsigned CMP_A_QUAL_BIT   = 2;
    localparam int unsigned CMP_B_DIR_BIT    = 1;
    localparam int unsigned CMP_B_QUAL_BIT   = 0;
    localparam int unsigned HOST_FORCED_RESET_BIT = 0;

    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [3:0]  CNT_FULL    = 4'h8;
    localparam logic [3:0]  CNT_ZERO    = 4'h0;
endpackage

//--- hw/dbg_reg_if.sv
// Register port between the debug module and its host
`timescale 1ns/1ps
`default_nettype none
interface dbg_reg_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       serial;
    logic [7:0] rdata;

    modport device (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        input  serial,
        output rdata
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        output serial,
        input  rdata
    );
endinterface
`default_nettype wire

//--- hw/dbg_trace.sv
// Debug comparators, capture fifo, control and forced reset
//
// Functional notes
// - Force-reset writes only via serial commands
// - Force-reset register always reads zero
// - Serial write of bit0 forces chip reset
// - Eight bytes of registers, all user-readable
// - Comparator bytes reset zero, locked while armed
// - Fifo high byte read-only, zero in event-only
// - High read keeps position, low read advances
// - Event-only stores bytes only, upper half zero
// - Low reads while armed do not advance
// - Unarmed low read stores last opcode address
// - Fifo eight words deep, ninth read wraps
// - Control register accessible at any time
// - Bit7 enables module, refused when secured
// - Bit6 arms run, auto-cleared on completion
// - Bit5 selects tag or force break
// - Break on match (end) or full (begin)
// - Bits 3:2 qualify comparator A direction
// - Bits 1:0 qualify comparator B direction
// - Run ends on full or end trigger
`timescale 1ns/1ps
`default_nettype none
module dbg_trace #(
    parameter int unsigned DEPTH = dbg_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    dbg_reg_if.device        regs,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic [7:0]  cpu_data_i,
    input  wire logic        cpu_access_i,
    input  wire logic        cpu_read_i,
    input  wire logic        opcode_fetch_i,
    input  wire logic        secure_i,
    input  wire logic        begin_trace_i,
    input  wire logic        event_only_i,
    output logic             break_req_o,
    output logic             break_tag_o,
    output logic             force_reset_o,
    output logic             armed_o,
    output logic [3:0]       valid_count_o
);
    logic [7:0]  cmp_a_high_ff;
    logic [7:0]  cmp_a_low_ff;
    logic [7:0]  cmp_b_high_ff;
    logic [7:0]  cmp_b_low_ff;
    logic [7:0]  control_ff;
    logic [15:0] fifo_ff [DEPTH];
    logic [15:0] last_opcode_ff;
    logic [3:0]  count_ff;
    logic        triggered_ff;
    logic [7:0]  rdata_ff;
    logic        break_req_ff;
    logic        force_reset_ff;

    logic        wr_cmp;
    logic        wr_ctrl;
    logic        match_a;
    logic        match_b;
    logic        trigger;
    logic        armed;
    logic        store;
    logic        shift;
    logic [15:0] shift_word;
    logic        becomes_full;
    logic        run_end;
    logic        nxt_enable;

    assign armed   = control_ff[dbg_pkg::ARM_BIT];
    assign wr_ctrl = regs.wr && regs.addr == dbg_pkg::CONTROL_IDX;
    // Compare values are frozen during a run
    assign wr_cmp  = regs.wr && !armed;

    // Comparators see the joined bytes and optional direction check
    assign match_a = cpu_access_i
        && cpu_addr_i == {cmp_a_high_ff, cmp_a_low_ff}
        && (!control_ff[dbg_pkg::CMP_A_QUAL_BIT]
            || cpu_read_i == control_ff[dbg_pkg::CMP_A_DIR_BIT]);
    assign match_b = cpu_access_i
        && cpu_addr_i == {cmp_b_high_ff, cmp_b_low_ff}
        && (!control_ff[dbg_pkg::CMP_B_QUAL_BIT]
            || cpu_read_i == control_ff[dbg_pkg::CMP_B_DIR_BIT]);

    assign trigger = armed && (event_only_i ? match_a : (match_a || match_b));

    // Event-only runs count as begin traces and store data bytes
    always_comb begin
        store      = 1'b0;
        shift_word = last_opcode_ff;
        if (armed) begin
            if (event_only_i) begin
                store      = match_b && (triggered_ff || match_a);
                shift_word = {dbg_pkg::BYTE_RESET, cpu_data_i};
            end else if (begin_trace_i) begin
                store      = opcode_fetch_i && (triggered_ff || trigger);
                shift_word = cpu_addr_i;
            end else begin
                store      = opcode_fetch_i;
                shift_word = cpu_addr_i;
            end
        end
    end

    assign becomes_full = store && count_ff == dbg_pkg::CNT_FULL - 4'h1;
    assign run_end = armed && ((begin_trace_i || event_only_i)
        ? becomes_full : trigger);

    // Low read shifts only when unarmed; profiling feeds the tail
    assign shift = store
        || (regs.rd && regs.addr == dbg_pkg::FIFO_LOW_IDX
            && !armed);

    // Comparator value bytes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_a_high_ff <= dbg_pkg::BYTE_RESET;
            cmp_a_low_ff  <= dbg_pkg::BYTE_RESET;
            cmp_b_high_ff <= dbg_pkg::BYTE_RESET;
            cmp_b_low_ff  <= dbg_pkg::BYTE_RESET;
        end else if (ce_i && wr_cmp) begin
            case (regs.addr)
                dbg_pkg::CMP_A_HIGH_IDX: cmp_a_high_ff <= regs.wdata;
                dbg_pkg::CMP_A_LOW_IDX:  cmp_a_low_ff  <= regs.wdata;
                dbg_pkg::CMP_B_HIGH_IDX: cmp_b_high_ff <= regs.wdata;
                dbg_pkg::CMP_B_LOW_IDX:  cmp_b_low_ff  <= regs.wdata;
                default: ;
            endcase
        end
    end

    // Control register; a software write beats the run-end clear
    always_comb begin
        nxt_enable = regs.wdata[dbg_pkg::ENABLE_BIT] && !secure_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            control_ff <= dbg_pkg::BYTE_RESET;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                control_ff <= regs.wdata;
                control_ff[dbg_pkg::ENABLE_BIT] <= nxt_enable;
                control_ff[dbg_pkg::ARM_BIT] <= nxt_enable
                    && regs.wdata[dbg_pkg::ARM_BIT];
            end else if (run_end) begin
                control_ff[dbg_pkg::ARM_BIT] <= 1'b0;
            end
        end
    end

    // Most recent opcode address, for profiling reads
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_opcode_ff <= dbg_pkg::WORD_RESET;
        end else if (ce_i && opcode_fetch_i) begin
            last_opcode_ff <= cpu_addr_i;
        end
    end

    // Shift-register fifo: head at entry 0, new words enter the tail
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_fifo
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    fifo_ff[gi] <= dbg_pkg::WORD_RESET;
                end else if (ce_i && shift) begin
                    if (gi == DEPTH - 1) begin
                        fifo_ff[gi] <= shift_word;
                    end else begin
                        fifo_ff[gi] <= fifo_ff[gi + 1];
                    end
                end
            end
        end
    endgenerate

    // Valid count and begin-trace trigger latch, cleared when armed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_ff     <= dbg_pkg::CNT_ZERO;
            triggered_ff <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl && nxt_enable && regs.wdata[dbg_pkg::ARM_BIT]) begin
                count_ff     <= dbg_pkg::CNT_ZERO;
                triggered_ff <= 1'b0;
            end else if (armed) begin
                if (store && count_ff != dbg_pkg::CNT_FULL) begin
                    count_ff <= count_ff + 4'h1;
                end
                if (trigger) begin
                    triggered_ff <= 1'b1;
                end
            end
        end
    end

    // Break requests; tag bit is meaningless without break enable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            break_req_ff <= 1'b0;
        end else if (ce_i) begin
            break_req_ff <= control_ff[dbg_pkg::BREAK_ENABLE_BIT]
                && run_end;
        end
    end

    // Forced reset only from serial commands; user writes drop
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            force_reset_ff <= 1'b0;
        end else if (ce_i) begin
            force_reset_ff <= regs.wr && regs.serial
                && regs.addr == dbg_pkg::FORCE_RESET_IDX
                && regs.wdata[dbg_pkg::HOST_FORCED_RESET_BIT];
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= dbg_pkg::BYTE_RESET;
        end else if (ce_i) begin
            if (regs.rd) begin
                case (regs.addr)
                    dbg_pkg::CMP_A_HIGH_IDX: rdata_ff <= cmp_a_high_ff;
                    dbg_pkg::CMP_A_LOW_IDX:  rdata_ff <= cmp_a_low_ff;
                    dbg_pkg::CMP_B_HIGH_IDX: rdata_ff <= cmp_b_high_ff;
                    dbg_pkg::CMP_B_LOW_IDX:  rdata_ff <= cmp_b_low_ff;
                    dbg_pkg::FIFO_HIGH_IDX:
                        rdata_ff <= event_only_i ? dbg_pkg::BYTE_RESET
                            : fifo_ff[0][15:8];
                    dbg_pkg::FIFO_LOW_IDX:   rdata_ff <= fifo_ff[0][7:0];
                    dbg_pkg::CONTROL_IDX:    rdata_ff <= control_ff;
                    dbg_pkg::FORCE_RESET_IDX:
                        rdata_ff <= dbg_pkg::BYTE_RESET;
                    default:                 rdata_ff <= dbg_pkg::BYTE_RESET;
                endcase
            end else begin
                rdata_ff <= dbg_pkg::BYTE_RESET;
            end
        end
    end

    assign regs.rdata    = rdata_ff;
    assign break_req_o   = break_req_ff;
    assign break_tag_o   = control_ff[dbg_pkg::TAG_BIT];
    assign force_reset_o = force_reset_ff;
    assign armed_o       = armed;
    assign valid_count_o = count_ff;
endmodule
`default_nettype wire

//--- tb/dbg_trace_assertions.sv
// Concurrent checks on the register port and the trace event outputs
`timescale 1ns/1ps
`default_nettype none
module dbg_trace_assertions (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       serial_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       force_reset_i,
    input  wire logic       armed_i,
    input  wire logic       break_req_i,
    input  wire logic [3:0] valid_count_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic frc_wr;
    logic ctl_wr;
    assign frc_wr = wr_i && addr_i == dbg_pkg::FORCE_RESET_IDX;
    assign ctl_wr = wr_i && addr_i == dbg_pkg::CONTROL_IDX;
    frc_read_zero_a: assert property (rd_i
        && addr_i == dbg_pkg::FORCE_RESET_IDX |=> rdata_i == 8'h00)
        else $error("force reset reads nonzero");
    frc_source_a: assert property (force_reset_i
        |-> $past(frc_wr && serial_i && wdata_i[0]))
        else $error("reset without serial write");
    frc_pulse_a: assert property (frc_wr && serial_i && wdata_i[0]
        |=> force_reset_i ##1 !force_reset_i)
        else $error("no reset pulse");
    ctl_arm_image_a: assert property (rd_i
        && addr_i == dbg_pkg::CONTROL_IDX
        |=> rdata_i[dbg_pkg::ARM_BIT] == $past(armed_i))
        else $error("arm bit image");
    arm_source_a: assert property ($rose(armed_i)
        |-> $past(ctl_wr && wdata_i[7:6] == 2'b11))
        else $error("arm without write");
    arm_stop_a: assert property (ctl_wr
        && wdata_i[7:6] != 2'b11 |=> !armed_i)
        else $error("run not stopped by write");
    count_bound_a: assert property (valid_count_i <= 4'h8)
        else $error("valid count above depth");
    brk_pulse_a: assert property (break_req_i |=> !break_req_i)
        else $error("break longer than a cycle");
    brk_end_a: assert property (break_req_i
        |-> $past(armed_i) && !armed_i)
        else $error("break without run end");
    cover property (force_reset_i);
    cover property (break_req_i);
    cover property ($fell(armed_i) && !$past(ctl_wr));
    cover property (rd_i && addr_i == dbg_pkg::FIFO_LOW_IDX && !armed_i);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Both ends joined by the register port, driven from host and CPU sides
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  c_addr = 4'h0;
    logic [7:0]  c_wdata = 8'h00;
    logic        c_wr = 1'b0, c_rd = 1'b0, c_word = 1'b0, c_ser = 1'b0;
    logic [15:0] a_addr = 16'h0000;
    logic [7:0]  a_data = 8'h00;
    logic        a_acc = 1'b0, a_rd = 1'b0, a_fetch = 1'b0;
    logic        secure = 1'b0, begin_tr = 1'b0, ev_only = 1'b0;
    logic        busy, b_valid, w_valid, brk, brk_tag, frc, armed;
    logic [7:0]  b_out, rv;
    logic [15:0] w_out, wv;
    logic [3:0]  count;
    int          failures = 0, cmp_count = 0, cycles = 0;
    int          brk_n = 0, frc_n = 0;
    logic        ce = 1'b1;
    dbg_reg_if rif ();
    dbg_trace u_dbg_trace (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .regs(rif.device), .cpu_addr_i(a_addr), .cpu_data_i(a_data),
        .cpu_access_i(a_acc), .cpu_read_i(a_rd), .opcode_fetch_i(a_fetch),
        .secure_i(secure), .begin_trace_i(begin_tr), .event_only_i(ev_only),
        .break_req_o(brk), .break_tag_o(brk_tag), .force_reset_o(frc),
        .armed_o(armed), .valid_count_o(count));
    dbg_host u_dbg_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .regs(rif.host), .cmd_addr_i(c_addr), .cmd_wdata_i(c_wdata),
        .cmd_wr_i(c_wr), .cmd_rd_i(c_rd), .cmd_word_rd_i(c_word),
        .cmd_serial_i(c_ser), .busy_o(busy), .byte_o(b_out),
        .byte_valid_o(b_valid), .word_o(w_out), .word_valid_o(w_valid));
    dbg_trace_assertions u_dbg_trace_assertions (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .addr_i(rif.addr), .wdata_i(rif.wdata),
        .wr_i(rif.wr), .rd_i(rif.rd), .serial_i(rif.serial),
        .rdata_i(rif.rdata), .force_reset_i(frc), .armed_i(armed),
        .break_req_i(brk), .valid_count_i(count));
    initial forever #4 clk_i = ~clk_i;
    // Pulse outputs counted one cycle late, so checks stay race free
    always @(posedge clk_i) begin
        cycles++;
        // Unknown pulses count too, so they cannot slip past a check
        if (!sys_rst_i && brk !== 1'b0) brk_n++;
        if (!sys_rst_i && frc !== 1'b0) frc_n++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e,
                         input string m);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e, string m);
        chk16({8'h00, g}, {8'h00, e}, m);
    endtask
    task automatic chk_cnt(input int g, input int e, input string m);
        chk16(16'(g), 16'(e), m);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic s);
        c_addr <= a;
        c_wdata <= d;
        c_ser <= s;
        c_wr <= 1'b1;
        @(posedge clk_i);
        c_wr <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wait_valid(input bit word);
        repeat (12) begin
            @(negedge clk_i);
            if ((word ? w_valid : b_valid) === 1'b1) break;
        end
        if ((word ? w_valid : b_valid) !== 1'b1) begin
            failures++;
            $display("Error %0t no answer from host", $time);
        end
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        c_addr <= a;
        c_rd <= 1'b1;
        @(posedge clk_i);
        c_rd <= 1'b0;
        wait_valid(1'b0);
        v = b_out;
    endtask
    task automatic rdw(output logic [15:0] v);
        c_word <= 1'b1;
        @(posedge clk_i);
        c_word <= 1'b0;
        @(negedge clk_i);
        chk8({7'h0, busy}, 8'h01, "host busy on word read");
        wait_valid(1'b1);
        repeat (2) @(posedge clk_i);
        v = w_out;
        chk8({7'h0, busy}, 8'h00, "host idle after word");
    endtask
    // Extra idle cycles let the break and arm updates land before checks
    task automatic cpu(input logic [15:0] a, input logic r, input logic f,
                       input logic [7:0] d);
        a_addr <= a;
        a_rd <= r;
        a_fetch <= f;
        a_data <= d;
        a_acc <= 1'b1;
        @(posedge clk_i);
        a_acc <= 1'b0;
        a_fetch <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic t_regs();
        logic [7:0] v [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), rv);
            chk8(rv, 8'h00, "comparator reset");
            wr(4'(i), v[i], 1'b0);
            rd(4'(i), rv);
            chk8(rv, v[i], "comparator readback");
        end
        rd(4'h7, rv);
        chk8(rv, 8'h00, "force reset at reset");
        rd(4'h8, rv);
        chk8(rv, 8'h00, "unmapped");
        wr(4'h7, 8'h01, 1'b0);
        chk_cnt(frc_n, 0, "user reset write");
        wr(4'h7, 8'h01, 1'b1);
        chk_cnt(frc_n, 1, "serial reset write");
        rd(4'h7, rv);
        chk8(rv, 8'h00, "force reset read");
        $display("registers and forced reset done");
    endtask
    task automatic t_ctrl();
        secure <= 1'b1;
        wr(4'h6, 8'h80, 1'b0);
        rd(4'h6, rv);
        chk8(rv, 8'h00, "enable while secured");
        secure <= 1'b0;
        wr(4'h6, 8'hc0, 1'b0);
        chk8({7'h0, armed}, 8'h01, "arm");
        wr(4'h0, 8'hff, 1'b0);
        rd(4'h0, rv);
        chk8(rv, 8'h12, "write while armed");
        rd(4'h6, rv);
        chk8(rv, 8'hc0, "control while armed");
        wr(4'h6, 8'h80, 1'b0);
        chk8({7'h0, armed}, 8'h00, "arm cleared");
        wr(4'h6, 8'hc0, 1'b0);
        wr(4'h6, 8'h40, 1'b0);
        chk8({7'h0, armed}, 8'h00, "disable stops run");
        $display("control done");
    endtask
    task automatic t_end(input logic [7:0] ctl, input logic [15:0] tgt,
                         input logic ok_rd);
        int b0;
        b0 = brk_n;
        wr(4'h6, ctl, 1'b0);
        for (int i = 0; i < 10; i++) cpu(16'h0200 + 16'(i), 1'b1, 1'b1, 8'h00);
        cpu(tgt, ~ok_rd, 1'b0, 8'h00);
        chk8({7'h0, armed}, 8'h01, "wrong direction");
        cpu(tgt, ok_rd, 1'b0, 8'h00);
        chk8({7'h0, armed}, 8'h00, "end trigger");
        chk_cnt(brk_n - b0, 1, "break count");
        chk8({7'h0, brk_tag}, {7'h0, ctl[5]}, "break type");
        for (int i = 2; i < 10; i++) begin
            rdw(wv);
            chk16(wv, 16'h0200 + 16'(i), "trace word");
        end
        $display("end trace done");
    endtask
    task automatic t_begin();
        int b0;
        b0 = brk_n;
        begin_tr <= 1'b1;
        wr(4'h6, 8'hd0, 1'b0);
        for (int i = 0; i < 7; i++) cpu(16'h1234 + 16'(i), 1'b1, 1'b1, 8'h00);
        chk8({4'h0, count}, 8'h07, "count before full");
        chk8({7'h0, armed}, 8'h01, "armed before full");
        cpu(16'h0400, 1'b1, 1'b1, 8'h00);
        chk8({4'h0, count}, 8'h08, "count full");
        chk8({7'h0, armed}, 8'h00, "full ends run");
        chk_cnt(brk_n - b0, 1, "break on full");
        begin_tr <= 1'b0;
        $display("begin trace done");
    endtask
    task automatic t_event();
        ev_only <= 1'b1;
        wr(4'h6, 8'hc0, 1'b0);
        cpu(16'h1234, 1'b1, 1'b0, 8'h00);
        for (int i = 0; i < 8; i++) cpu(16'h5678, 1'b0, 1'b0, 8'ha0 + 8'(i));
        chk8({7'h0, armed}, 8'h00, "event fifo full");
        wr(4'h4, 8'hff, 1'b0);
        rdw(wv);
        chk16(wv, 16'h00a0, "event word");
        for (int i = 1; i < 8; i++) begin
            rd(4'h5, rv);
            chk8(rv, 8'ha0 + 8'(i), "event byte");
        end
        ev_only <= 1'b0;
        $display("event only done");
    endtask
    task automatic t_profile();
        for (int i = 0; i < 9; i++) begin
            cpu(16'h3000 + 16'(i), 1'b1, 1'b1, 8'h00);
            rdw(wv);
        end
        chk16(wv, 16'h3000, "ninth profile read");
        wr(4'h6, 8'hc0, 1'b0);
        rd(4'h5, rv);
        rd(4'h5, rv);
        chk8(rv, 8'h01, "armed read holds");
        wr(4'h6, 8'h00, 1'b0);
        $display("profiling done");
    endtask
    // A match while the clock enable is low must change nothing
    task automatic t_freeze();
        wr(4'h6, 8'hc0, 1'b0);
        ce <= 1'b0;
        cpu(16'h1234, 1'b1, 1'b1, 8'h00);
        chk8({7'h0, armed}, 8'h01, "frozen run end");
        chk8({4'h0, count}, 8'h00, "frozen store");
        ce <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk8({7'h0, armed}, 8'h01, "armed after thaw");
        wr(4'h6, 8'h00, 1'b0);
        $display("clock enable done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_ctrl();
        t_end(8'hdc, 16'h1234, 1'b1);
        t_end(8'hf1, 16'h5678, 1'b0);
        t_begin();
        t_event();
        t_profile();
        t_freeze();
        complete_run();
    end
endmodule
`default_nettype wire
